/* File: pmr_pkg.sv */
// Constants and types for the management status and 10Base-T operations registers
// Overview of operation
// - Latch PLL lock error high while 100 Mb/s recovery loop is unlocked
// - Latch false carrier when a start delimiter proves not to be J/K
// - Invalid symbol inside a 100 Mb/s packet drives RXER and latches status
// - Halt code group inside a valid packet signals MAC and latches status
// - Two idles inside a valid packet signal MAC and latch premature end
// - Negotiation complete bit is one only when enabled, done and registers valid
// - Signal detect bit follows receive signal presence live in 100Base-TX
// - Jabber bit mirrors the basic status register jabber bit
// - Remote fault bit mirrors the basic status register remote fault bit
// - Link bit mirrors the basic status link bit, latch-low included
// - Remote jabber bit clears on operations register read and on reset
// - Receive path jabber criteria latch remote jabber; informational only
// - Polarity reversed latches when receive pair is swapped; operation continues
// - Jabber inhibit one skips the transmit jabber check
// - Auto-polarity inhibit one stops automatic polarity correction
// - SQE test inhibit one stops SQE test pulse generation
// - Link loss inhibit one forces the 10Base-T link to passed
// - Squelch inhibit one requires valid data then idle before link
package pmr_pkg;
  localparam logic [4:0] PHY_ADDR = 5'h01;
  localparam logic [4:0] REG_HUNDRED = 5'h11;
  localparam logic [4:0] REG_TENBASE = 5'h12;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [5:0] PRE_BITS = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0c;
  localparam logic [5:0] DATA_LAST = 6'h0f;
  localparam int B18_JAB_INH = 5;
  localparam int B18_APOL_INH = 3;
  localparam int B18_SQE_INH = 2;
  localparam int B18_LINK_INH = 1;
  localparam int B18_SQ_INH = 0;
  localparam logic [13:0] CTL_RESET = 14'h0110;
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned JAB_TIME_US = 20000;
  typedef enum logic [2:0] {PMR_PRE, PMR_HDR, PMR_TA, PMR_RD, PMR_WR} pmr_state_t;
  typedef struct packed {
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mdi_s1;
    logic mdi_s2;
    pmr_state_t st;
    logic [5:0] cnt;
    logic [15:0] sr;
    logic op_rd;
    logic [4:0] regad;
    logic mdo;
    logic mdo_en;
    logic [4:0] lh17;
    logic rjab;
    logic pol;
    logic [13:0] ctl;
    logic [21:0] jab_cnt;
    logic rx_er;
  } pmr_regs_t;
endpackage : pmr_pkg

/* File: pmr_regs.sv */
// Management register bank with serial management slave
`timescale 1ns/100ps
module pmr_regs #(
  parameter int unsigned JAB_CYC = pmr_pkg::JAB_TIME_US * 1000 / pmr_pkg::CLK_NS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic speed_100,
  input wire logic pll_unlocked,
  input wire logic false_carrier_evt,
  input wire logic rx_in_packet,
  input wire logic invalid_symbol_evt,
  input wire logic halt_symbol_evt,
  input wire logic premature_end_evt,
  input wire logic an_enable,
  input wire logic an_done,
  input wire logic an_regs_valid,
  input wire logic signal_present,
  input wire logic jabber_status,
  input wire logic remote_fault_status,
  input wire logic link_status,
  input wire logic rx_carrier_10,
  input wire logic polarity_swapped,
  output logic mii_rx_er,
  output logic jabber_check_en,
  output logic auto_polarity_en,
  output logic sqe_test_en,
  output logic link_force_pass,
  output logic squelch_need_idle
);
  import pmr_pkg::*;

  pmr_regs_t s;
  pmr_regs_t n;
  logic mdc_rise;
  logic rd17;
  logic rd18;
  logic jab_evt;
  logic [4:0] ev17;
  logic [12:0] hdr;
  logic [15:0] rdata;

  assign mdc_rise = s.mdc_s2 & ~s.mdc_s3;
  assign jab_evt = rx_carrier_10 && (s.jab_cnt == 22'(JAB_CYC - 1));
  // Conditions gated to 100 Mb/s since the bits mean nothing at 10 Mb/s
  assign ev17 = {pll_unlocked, false_carrier_evt,
                 rx_in_packet & invalid_symbol_evt,
                 rx_in_packet & halt_symbol_evt,
                 rx_in_packet & premature_end_evt} & {5{speed_100}};
  assign hdr = {s.sr[11:0], s.mdi_s2};

  always_comb begin
    rdata = 16'h0000;
    if (s.regad == REG_HUNDRED) begin
      rdata = {6'h00, s.lh17,
               an_enable & an_done & an_regs_valid,
               speed_100 & signal_present,
               jabber_status,
               remote_fault_status,
               link_status};
    end else if (s.regad == REG_TENBASE) begin
      rdata = {s.rjab, s.pol, s.ctl};
    end
  end

  always_comb begin
    n = s;
    rd17 = 1'b0;
    rd18 = 1'b0;
    n.mdc_s1 = mdc;
    n.mdc_s2 = s.mdc_s1;
    n.mdc_s3 = s.mdc_s2;
    n.mdi_s1 = mdio_in;
    n.mdi_s2 = s.mdi_s1;
    if (mdc_rise) begin
      case (s.st)
        PMR_PRE: begin
          if (s.mdi_s2) begin
            if (s.cnt != PRE_BITS) begin
              n.cnt = s.cnt + 6'h01;
            end
          end else if (s.cnt == PRE_BITS) begin
            n.st = PMR_HDR;
            n.cnt = 6'h00;
          end else begin
            n.cnt = 6'h00;
          end
        end
        PMR_HDR: begin
          n.sr = {s.sr[14:0], s.mdi_s2};
          n.cnt = s.cnt + 6'h01;
          if (s.cnt == HDR_LAST) begin
            n.cnt = 6'h00;
            n.regad = hdr[4:0];
            n.op_rd = (hdr[11:10] == OP_READ);
            // Frames for another address or with a bad opcode are skipped
            if (hdr[12] && hdr[9:5] == PHY_ADDR &&
                (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
              n.st = PMR_TA;
            end else begin
              n.st = PMR_PRE;
            end
          end
        end
        PMR_TA: begin
          n.cnt = s.cnt + 6'h01;
          if (s.cnt == 6'h00) begin
            if (s.op_rd) begin
              n.mdo = 1'b0;
              n.mdo_en = 1'b1;
              n.sr = rdata;
              rd17 = (s.regad == REG_HUNDRED);
              rd18 = (s.regad == REG_TENBASE);
            end
          end else begin
            n.cnt = 6'h00;
            if (s.op_rd) begin
              n.st = PMR_RD;
              n.mdo = s.sr[15];
              n.sr = {s.sr[14:0], 1'b0};
            end else begin
              n.st = PMR_WR;
            end
          end
        end
        PMR_RD: begin
          n.cnt = s.cnt + 6'h01;
          n.mdo = s.sr[15];
          n.sr = {s.sr[14:0], 1'b0};
          if (s.cnt == DATA_LAST) begin
            n.mdo_en = 1'b0;
            n.mdo = 1'b0;
            n.st = PMR_PRE;
            n.cnt = 6'h00;
          end
        end
        PMR_WR: begin
          n.cnt = s.cnt + 6'h01;
          n.sr = {s.sr[14:0], s.mdi_s2};
          if (s.cnt == DATA_LAST) begin
            n.st = PMR_PRE;
            n.cnt = 6'h00;
            // Reserved bits are stored as written; the manager keeps defaults
            if (s.regad == REG_TENBASE) begin
              n.ctl = {s.sr[12:0], s.mdi_s2};
            end
          end
        end
        default: begin
          n.st = PMR_PRE;
        end
      endcase
    end
    // Set beats clear so an event during the read is kept for the next one
    n.lh17 = (s.lh17 & ~{5{rd17}}) | ev17;
    n.rjab = (s.rjab & ~rd18) | jab_evt;
    n.pol = (s.pol & ~rd18) | polarity_swapped;
    if (!rx_carrier_10) begin
      n.jab_cnt = 22'h00_0000;
    end else if (!jab_evt) begin
      n.jab_cnt = s.jab_cnt + 22'h00_0001;
    end
    n.rx_er = speed_100 & rx_in_packet &
              (invalid_symbol_evt | halt_symbol_evt | premature_end_evt);
    if (rst) begin
      n = '0;
      n.ctl = CTL_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    s <= n;
  end

  assign mdio_out = s.mdo;
  assign mdio_oe_n = ~s.mdo_en;
  assign mii_rx_er = s.rx_er;
  assign jabber_check_en = ~s.ctl[B18_JAB_INH];
  assign auto_polarity_en = ~s.ctl[B18_APOL_INH];
  assign sqe_test_en = ~s.ctl[B18_SQE_INH];
  assign link_force_pass = s.ctl[B18_LINK_INH];
  assign squelch_need_idle = s.ctl[B18_SQ_INH];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_pll_latch: assert property (speed_100 && pll_unlocked |=> s.lh17[4])
    else $error("pll lock error not latched");
  chk_false_carrier: assert property (speed_100 && false_carrier_evt |=> s.lh17[3])
    else $error("false carrier not latched");
  chk_invalid_rxer: assert property (speed_100 && rx_in_packet && invalid_symbol_evt
    |=> mii_rx_er && s.lh17[2])
    else $error("invalid symbol not reported");
  chk_halt_latch: assert property (speed_100 && rx_in_packet && halt_symbol_evt
    |=> mii_rx_er && s.lh17[1])
    else $error("halt symbol not reported");
  chk_prem_end: assert property (speed_100 && rx_in_packet && premature_end_evt
    |=> mii_rx_er && s.lh17[0])
    else $error("premature end not reported");
  chk_an_gate: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_HUNDRED && !an_enable |=> !s.sr[4])
    else $error("negotiation complete read high while disabled");
  chk_read_clear: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_TENBASE && !jab_evt |=> !s.rjab)
    else $error("remote jabber not cleared by read");
  chk_jab_latch: assert property (jab_evt |=> s.rjab)
    else $error("remote jabber not latched");
  chk_pol_latch: assert property (polarity_swapped |=> s.pol ##1 (s.pol || !$past(rd18)))
    else $error("polarity reversal not latched");
  chk_jab_inhibit: assert property (mdc_rise && s.st == PMR_WR && s.cnt == DATA_LAST
    && s.regad == REG_TENBASE |=> jabber_check_en == !$past(s.sr[4]))
    else $error("jabber inhibit not applied");
  chk_mdio_release: assert property (mdc_rise && s.st == PMR_RD && s.cnt == DATA_LAST
    |=> mdio_oe_n ##1 mdio_oe_n)
    else $error("mdio not released after read data");
  chk_rxer_quiet: assert property (!(speed_100 && rx_in_packet && (invalid_symbol_evt
    || halt_symbol_evt || premature_end_evt)) |=> !mii_rx_er)
    else $error("receive error raised without an event");
  chk_pll_hold: assert property (s.lh17[4] && !rd17 |=> s.lh17[4])
    else $error("pll lock error latch lost");
  chk_pll_slow: assert property (!speed_100 && !s.lh17[4] |=> !s.lh17[4])
    else $error("pll lock error set at 10 Mb/s");
  chk_fc_hold: assert property (s.lh17[3] && !rd17 |=> s.lh17[3])
    else $error("false carrier latch lost");
  chk_inv_hold: assert property (s.lh17[2] && !rd17 |=> s.lh17[2])
    else $error("invalid symbol latch lost");
  chk_inv_gate: assert property (!rx_in_packet && !s.lh17[2] |=> !s.lh17[2])
    else $error("invalid symbol set outside a packet");
  chk_halt_hold: assert property (s.lh17[1] && !rd17 |=> s.lh17[1])
    else $error("halt symbol latch lost");
  chk_prem_hold: assert property (s.lh17[0] && !rd17 |=> s.lh17[0])
    else $error("premature end latch lost");
  chk_an_done: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_HUNDRED && an_enable && an_done && an_regs_valid |=> s.sr[4])
    else $error("negotiation complete read low when done");
  chk_an_busy: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_HUNDRED && !an_done |=> !s.sr[4])
    else $error("negotiation complete read high while busy");
  chk_sd_read: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_HUNDRED && speed_100 && signal_present |=> s.sr[3])
    else $error("signal detect read low while present");
  chk_sd_absent: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_HUNDRED && !signal_present |=> !s.sr[3])
    else $error("signal detect read high while absent");
  chk_jab_mirror: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_HUNDRED |=> s.sr[2] == $past(jabber_status))
    else $error("jabber bit does not mirror basic status");
  chk_fault_mirror: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_HUNDRED |=> s.sr[1] == $past(remote_fault_status))
    else $error("remote fault bit does not mirror basic status");
  chk_link_mirror: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_HUNDRED |=> s.sr[0] == $past(link_status))
    else $error("link bit does not mirror basic status");
  chk_rd17_clear: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    && s.regad == REG_HUNDRED && !speed_100 |=> s.lh17 == 5'h00)
    else $error("status latches not cleared by read");
  chk_rjab_hold: assert property (s.rjab && !rd18 |=> s.rjab)
    else $error("remote jabber latch lost");
  chk_rjab_quiet: assert property (!rx_carrier_10 && !s.rjab |=> !s.rjab)
    else $error("remote jabber set without receive activity");
  chk_pol_hold: assert property (s.pol && !rd18 |=> s.pol)
    else $error("polarity latch lost");
  chk_ctl_stable: assert property (!(mdc_rise && s.st == PMR_WR && s.cnt == DATA_LAST
    && s.regad == REG_TENBASE) |=> $stable(s.ctl))
    else $error("control bits changed without a write");
  chk_apol_write: assert property (mdc_rise && s.st == PMR_WR && s.cnt == DATA_LAST
    && s.regad == REG_TENBASE |=> auto_polarity_en == !$past(s.sr[2]))
    else $error("auto polarity inhibit not applied");
  chk_sqe_write: assert property (mdc_rise && s.st == PMR_WR && s.cnt == DATA_LAST
    && s.regad == REG_TENBASE |=> sqe_test_en == !$past(s.sr[1]))
    else $error("sqe test inhibit not applied");
  chk_link_write: assert property (mdc_rise && s.st == PMR_WR && s.cnt == DATA_LAST
    && s.regad == REG_TENBASE |=> link_force_pass == $past(s.sr[0]))
    else $error("link loss inhibit not applied");
  chk_sq_write: assert property (mdc_rise && s.st == PMR_WR && s.cnt == DATA_LAST
    && s.regad == REG_TENBASE |=> squelch_need_idle == $past(s.mdi_s2))
    else $error("squelch inhibit not applied");
  chk_ta_drive: assert property (mdc_rise && s.st == PMR_TA && s.cnt == 6'h00 && s.op_rd
    |=> !mdio_oe_n && !mdio_out)
    else $error("turnaround zero not driven");
  chk_hdr_quiet: assert property (s.st == PMR_HDR |-> mdio_oe_n)
    else $error("mdio driven during header");
  chk_wr_quiet: assert property (s.st == PMR_WR |-> mdio_oe_n)
    else $error("mdio driven during write data");
endmodule : pmr_regs

/* File: pmr_sta.sv */
// Station management model driving the serial management pins
`timescale 1ns/100ps
module pmr_sta (
  input wire logic mclk,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  output logic mdc,
  output logic mdio_in,
  output logic rd_done,
  output logic [15:0] rd_data
);
  import pmr_pkg::*;
  logic drv = 1'h1;
  logic drv_en = 1'h1;
  // Released line floats to the pull-up level, never to a stale value
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv : 1'h1);
  initial begin
    mdc = 1'h0;
    rd_done = 1'h0;
    rd_data = 16'h0000;
  end
  // Low 4 cycles then high 5, sampled as the line rises
  task automatic bitx(input logic b, output logic s);
    @(posedge mclk);
    mdc <= 1'h0;
    drv <= b;
    repeat (4) @(posedge mclk);
    s = mdio_in;
    mdc <= 1'h1;
    repeat (4) @(posedge mclk);
  endtask : bitx
  task automatic xfer(input logic [4:0] phy, input logic wr, input logic [4:0] ra,
                      input logic [15:0] wd);
    logic [45:0] hdr;
    logic s;
    hdr = {32'hffff_ffff, 2'b01, wr ? OP_WRITE : OP_READ, phy, ra};
    for (int i = 45; i >= 0; i--) bitx(hdr[i], s);
    drv_en <= wr;
    for (int i = 17; i >= 0; i--) begin
      bitx(i == 17 ? 1'h1 : (i == 16 ? 1'h0 : wd[i]), s);
      if (i < 16) rd_data[i] = s;
    end
    drv_en <= 1'h1;
    drv <= 1'h1;
    @(posedge mclk);
    rd_done <= !wr;
    @(posedge mclk);
    rd_done <= 1'h0;
    repeat (8) @(posedge mclk);
  endtask : xfer
endmodule : pmr_sta

/* File: pmr_regs_tb.sv */
// Self-checking bench for the management register bank
`timescale 1ns/100ps
module pmr_regs_tb;
  import pmr_pkg::*;
  logic mclk = 1'h0, rst = 1'h1, speed_100 = 1'h0, pll_unlocked = 1'h0;
  logic false_carrier_evt = 1'h0, rx_in_packet = 1'h0, invalid_symbol_evt = 1'h0;
  logic halt_symbol_evt = 1'h0, premature_end_evt = 1'h0, an_enable = 1'h0;
  logic an_done = 1'h0, an_regs_valid = 1'h0, signal_present = 1'h0;
  logic jabber_status = 1'h0, remote_fault_status = 1'h0, link_status = 1'h0;
  logic rx_carrier_10 = 1'h0, polarity_swapped = 1'h0;
  logic mdc, mdio_in, mdio_out, mdio_oe_n, mii_rx_er, jabber_check_en, auto_polarity_en;
  logic sqe_test_en, link_force_pass, squelch_need_idle, rd_done;
  logic [15:0] rd_data;
  logic [15:0] exp_q[$];
  logic [31:0] r;
  int failures = 0;
  int checks_done = 0;
  int seed = 32'h02e4_70b4;
  always #4 mclk = ~mclk;
  // Short jabber window keeps the run brief
  pmr_regs #(.JAB_CYC(16)) u_pmr_regs (.mclk(mclk), .rst(rst), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .speed_100(speed_100),
    .pll_unlocked(pll_unlocked), .false_carrier_evt(false_carrier_evt),
    .rx_in_packet(rx_in_packet), .invalid_symbol_evt(invalid_symbol_evt),
    .halt_symbol_evt(halt_symbol_evt), .premature_end_evt(premature_end_evt),
    .an_enable(an_enable), .an_done(an_done), .an_regs_valid(an_regs_valid),
    .signal_present(signal_present), .jabber_status(jabber_status),
    .remote_fault_status(remote_fault_status), .link_status(link_status),
    .rx_carrier_10(rx_carrier_10), .polarity_swapped(polarity_swapped),
    .mii_rx_er(mii_rx_er), .jabber_check_en(jabber_check_en),
    .auto_polarity_en(auto_polarity_en), .sqe_test_en(sqe_test_en),
    .link_force_pass(link_force_pass), .squelch_need_idle(squelch_need_idle));
  pmr_sta u_pmr_sta (.mclk(mclk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
    .mdio_in(mdio_in), .rd_done(rd_done), .rd_data(rd_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] e);
    exp_q.push_back(e);
    u_pmr_sta.xfer(phy, 1'h0, ra, 16'h0000);
  endtask : rd
  task automatic ctl(input logic [4:0] e);
    check({11'h000, jabber_check_en, auto_polarity_en, sqe_test_en, link_force_pass,
           squelch_need_idle}, {11'h000, e});
  endtask : ctl
  // Oldest note is matched against each completed read
  always @(posedge mclk) if (rd_done === 1'h1) check(rd_data, exp_q.pop_front());
  initial begin
    repeat (50000) @(posedge mclk);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    repeat (4) @(posedge mclk);
    ctl(5'h1c);
    rd(PHY_ADDR, REG_TENBASE, 16'h0110);
    // Reserved bits keep their defaults on every write
    u_pmr_sta.xfer(PHY_ADDR, 1'h1, REG_TENBASE, 16'h013f);
    ctl(5'h03);
    rd(PHY_ADDR, REG_TENBASE, 16'h013f);
    u_pmr_sta.xfer(PHY_ADDR, 1'h1, REG_TENBASE, 16'h0110);
    ctl(5'h1c);
    $display("test control done");
    r = $random(seed);
    speed_100 <= 1'h1;
    {an_enable, an_done, an_regs_valid, signal_present} <= 4'hf;
    {jabber_status, remote_fault_status, link_status} <= r[2:0];
    {pll_unlocked, false_carrier_evt, rx_in_packet} <= 3'h7;
    @(posedge mclk);
    {pll_unlocked, false_carrier_evt} <= 2'h0;
    for (int i = 0; i < 3; i++) begin
      {invalid_symbol_evt, halt_symbol_evt, premature_end_evt} <= 3'h4 >> i;
      @(posedge mclk);
      {invalid_symbol_evt, halt_symbol_evt, premature_end_evt} <= 3'h0;
      // Error flag stands only in the cycle after the event
      #1 check({15'h0000, mii_rx_er}, 16'h0001);
      @(posedge mclk);
    end
    rx_in_packet <= 1'h0;
    rd(PHY_ADDR, REG_HUNDRED, {13'h007f, r[2:0]});
    rd(PHY_ADDR, REG_HUNDRED, {13'h0003, r[2:0]});
    $display("test status done");
    {speed_100, an_enable, polarity_swapped, rx_carrier_10} <= 4'h3;
    @(posedge mclk);
    polarity_swapped <= 1'h0;
    repeat (20) @(posedge mclk);
    rx_carrier_10 <= 1'h0;
    rd(PHY_ADDR, REG_HUNDRED, {13'h0000, r[2:0]});
    rd(PHY_ADDR, REG_TENBASE, 16'hc110);
    rd(PHY_ADDR, REG_TENBASE, 16'h0110);
    $display("test jabber done");
    rd(PHY_ADDR, 5'h05, 16'h0000);
    rd(5'h02, REG_TENBASE, 16'hffff);
    repeat (4) @(posedge mclk);
    check(16'(exp_q.size()), 16'h0000);
    $display("test refusals done");
    wrap_up();
  end
endmodule : pmr_regs_tb
